/* File: logic/clock_ratio_pkg.sv */
// Package: register map, field layout, codes and timing of the clock ratio control
package clock_ratio_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [4:0] RATIO0_OFFSET    = 5'h00;
    localparam logic [4:0] RATIO1_OFFSET    = 5'h04;
    localparam logic [4:0] RATIO2_OFFSET    = 5'h08;
    localparam logic [4:0] RATIO3_OFFSET    = 5'h0C;
    localparam logic [4:0] MODAL_OFFSET     = 5'h10;
    localparam logic [4:0] GLOBAL_OFFSET    = 5'h14;
    localparam logic [4:0] STATUS_OFFSET    = 5'h18;
    localparam logic [4:0] EFFECTIVE_OFFSET = 5'h1C;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MODAL_SET_W      = 4;
    localparam int GLB_LOCK_CFG_BIT = 0;
    localparam int GLB_UNLOCK_BIT   = 1;
    localparam int GLB_FORMAT_BIT   = 2;
    localparam int GLB_SPECIAL_LSB  = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] RATIO_RESET  = 32'h0000_1000;
    localparam logic [15:0] MODAL_RESET  = 16'hAAAA;
    localparam logic [5:0]  GLOBAL_RESET = 6'h00;

    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [2:0] SPF_MAIN_DIS  = 3'h0;
    localparam logic [2:0] SPF_AUX_DIS   = 3'h1;
    localparam logic [2:0] SPF_BOTH_DIS  = 3'h2;
    localparam logic [2:0] SPF_RMOD_EN   = 3'h3;
    localparam logic [2:0] SPF_FORCE_AUX = 3'h7;
    localparam logic [1:0] AUX_RESERVED  = 2'h0;
    localparam logic [1:0] AUX_REF       = 2'h1;
    localparam logic [1:0] AUX_SYNTH     = 2'h2;
    localparam logic [1:0] AUX_LOCK      = 2'h3;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int MODE_SETTLE_NS   = 200;
    localparam int MODE_SETTLE_CYC  = (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_TIMEOUT_NS   = 25000000;
    localparam int REF_TIMEOUT_CYC  = REF_TIMEOUT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] auxSrc;
        logic [1:0] divSel;
    } modal_set_t;

    typedef struct packed {
        logic [2:0] specialFunc;
        logic       ratioFormat;
        logic       outputOnUnlock;
        logic       lockDriveCfg;
    } global_cfg_t;

    typedef struct packed {
        logic mainDis;
        logic auxDis;
        logic rmodEn;
        logic forceSynth;
    } special_ctl_t;

endpackage

/* File: logic/clock_ratio_mode_output_ctrl.sv */
// Ratio selection, output gating and mode pin decoding around a fractional-N PLL core
// Function
// - Divider select 00/01/10/11 scales ratio by 0.5/0.25/0.125/0.0625.
// - Scaling acts on the selected ratio only; stored ratios stay unchanged.
// - Effective ratio is selected ratio times modifier when modifier enabled.
// - Two mode pins pick one of four sets: ratio, divider, aux source.
// - Global settings are single values, never switched by mode pins.
// - Unlock holds main output low unless output-on-unlock is set.
// - Special pin tristates main output for function 000 or 010.
// - Aux mux drives reference clock, synthesized clock or lock indicator.
// - Aux source 01 reference, 10 synthesized, 11 lock, 00 reserved.
// - Lock drive config sets driver type and polarity of lock indicator.
// - Config 0 push-pull high on unlock; config 1 open drain low on unlock.
// - Special pin tristates aux output for function 001 or 010.
// - For 000/001/010 special pin high disables, low enables outputs.
// - For 011 special pin high applies divider select, low ignores it.
// - For 111 special pin high forces aux source to synthesized clock.
// - Enable, disable and unlock gating never cut a partial clock period.
// - Lock indicator and source changes may glitch; 01/10 switches wait only for old source low.
// - Any mode pin change drops lock while the new set settles.
// - Special pin change drops lock for functions 011 to 110.
// - Lost or stepped reference clock reports unlocked.
// - After lock the outputs follow the configuration chosen by mode pins.
// - Format select reads ratio as 20.12 or 12.20 fixed point.
`timescale 1ns/1ns
module clock_ratio_mode_output_ctrl
    import clock_ratio_pkg::*;
#(
    parameter int REF_TIMEOUT_CYCLES = REF_TIMEOUT_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        modeSelectLow,
    input  wire logic        modeSelectHigh,
    input  wire logic        specialFunctionPin,
    input  wire logic        pllLock,
    input  wire logic        synthClk,
    input  wire logic        refClk,
    output logic             mainClkOut,
    output logic             mainClkOe_n,
    output logic             auxOut,
    output logic             auxOe_n,
    output logic [31:0]      effectiveRatio,
    output logic             ratioFormatSelect,
    output logic             lockDropReq
);

    localparam int REF_W  = $clog2(REF_TIMEOUT_CYCLES + 1);
    localparam int DROP_W = $clog2(MODE_SETTLE_CYC + 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] applyStrobe(input logic [31:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[8*i +: 8] = data[8*i +: 8];
        end
        return res;
    endfunction

    function automatic special_ctl_t decodeSpecial(input logic [2:0] func, input logic pin);
        special_ctl_t s;
        s = '0;
        unique case (func)
            SPF_MAIN_DIS:  s.mainDis = pin;
            SPF_AUX_DIS:   s.auxDis = pin;
            SPF_BOTH_DIS:
            begin
                s.mainDis = pin;
                s.auxDis  = pin;
            end
            SPF_RMOD_EN:   s.rmodEn = pin;
            SPF_FORCE_AUX: s.forceSynth = pin;
            default:       s = '0;
        endcase
        return s;
    endfunction

    // ----------------------------------------
    // Input synchronizers
    // ----------------------------------------
    logic [5:0] syncA_reg;
    logic [5:0] syncB_reg;
    logic [5:0] pinsRaw;

    assign pinsRaw = {refClk, synthClk, pllLock, specialFunctionPin, modeSelectHigh, modeSelectLow};

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            syncA_reg <= 6'h00;
            syncB_reg <= 6'h00;
        end
        else
        begin
            syncA_reg <= pinsRaw;
            syncB_reg <= syncA_reg;
        end
    end

    logic [1:0] modeIdx;
    logic       spPin;
    logic       lockIn;
    logic       synthS;
    logic       refS;

    assign modeIdx = syncB_reg[1:0];
    assign spPin   = syncB_reg[2];
    assign lockIn  = syncB_reg[3];
    assign synthS  = syncB_reg[4];
    assign refS    = syncB_reg[5];

    // ----------------------------------------
    // Configuration store and bus slave
    // ----------------------------------------
    logic [3:0][31:0] ratio_reg, ratio_next;
    logic [15:0]      modal_reg, modal_next;
    global_cfg_t      global_reg, global_next;
    logic             awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
    logic [4:0]       awAddr_reg, awAddr_next;
    logic [31:0]      wData_reg, wData_next;
    logic [3:0]       wStrb_reg, wStrb_next;
    logic             awready_reg, awready_next, wready_reg, wready_next;
    logic             bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0]       bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0]      rdata_reg, rdata_next;
    logic             doWrite;
    logic [31:0]      statusWord;
    logic [31:0]      modalWord, globalWord;

    always_comb
    begin
        ratio_next   = ratio_reg;
        modal_next   = modal_reg;
        global_next  = global_reg;
        awHeld_next  = awHeld_reg | (awvalid & awready_reg);
        wHeld_next   = wHeld_reg | (wvalid & wready_reg);
        awAddr_next  = (awvalid & awready_reg) ? awaddr : awAddr_reg;
        wData_next   = (wvalid & wready_reg) ? wdata : wData_reg;
        wStrb_next   = (wvalid & wready_reg) ? wstrb : wStrb_reg;
        modalWord    = applyStrobe({16'h0000, modal_reg}, wData_next, wStrb_next);
        globalWord   = applyStrobe({26'h0, global_reg}, wData_next, wStrb_next);
        bvalid_next  = bvalid_reg & ~bready;
        bresp_next   = bresp_reg;
        doWrite      = awHeld_next & wHeld_next & ~bvalid_reg;
        if (doWrite)
        begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            unique case (awAddr_next)
                RATIO0_OFFSET: ratio_next[0] = applyStrobe(ratio_reg[0], wData_next, wStrb_next);
                RATIO1_OFFSET: ratio_next[1] = applyStrobe(ratio_reg[1], wData_next, wStrb_next);
                RATIO2_OFFSET: ratio_next[2] = applyStrobe(ratio_reg[2], wData_next, wStrb_next);
                RATIO3_OFFSET: ratio_next[3] = applyStrobe(ratio_reg[3], wData_next, wStrb_next);
                MODAL_OFFSET:  modal_next = modalWord[15:0];
                GLOBAL_OFFSET: global_next = globalWord[5:0];
                default:       bresp_next = RESP_SLVERR;
            endcase
        end
        awready_next = ~awHeld_next & ~bvalid_next;
        wready_next  = ~wHeld_next & ~bvalid_next;
        rvalid_next  = rvalid_reg & ~rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (arvalid & arready_reg)
        begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            unique case (araddr)
                RATIO0_OFFSET:    rdata_next = ratio_reg[0];
                RATIO1_OFFSET:    rdata_next = ratio_reg[1];
                RATIO2_OFFSET:    rdata_next = ratio_reg[2];
                RATIO3_OFFSET:    rdata_next = ratio_reg[3];
                MODAL_OFFSET:     rdata_next = {16'h0000, modal_reg};
                GLOBAL_OFFSET:    rdata_next = {26'h0, global_reg};
                STATUS_OFFSET:    rdata_next = statusWord;
                EFFECTIVE_OFFSET: rdata_next = effectiveRatio;
                default:
                begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ratio_reg   <= {4{RATIO_RESET}};
            modal_reg   <= MODAL_RESET;
            global_reg  <= GLOBAL_RESET;
            awHeld_reg  <= 1'b0;
            wHeld_reg   <= 1'b0;
            awAddr_reg  <= 5'h00;
            wData_reg   <= 32'h0000_0000;
            wStrb_reg   <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
        end
        else
        begin
            ratio_reg   <= ratio_next;
            modal_reg   <= modal_next;
            global_reg  <= global_next;
            awHeld_reg  <= awHeld_next;
            wHeld_reg   <= wHeld_next;
            awAddr_reg  <= awAddr_next;
            wData_reg   <= wData_next;
            wStrb_reg   <= wStrb_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rresp   = rresp_reg;
    assign rdata   = rdata_reg;

    // ----------------------------------------
    // Mode decode, lock tracking, ratio
    // ----------------------------------------
    modal_set_t     modalSel;
    special_ctl_t   spec;
    logic [31:0]    curRatio;
    logic           lockEff;
    logic           refEdge;
    logic           refLost;
    logic [1:0]     auxSrcSel;
    logic [REF_W-1:0]  refCnt_reg, refCnt_next;
    logic [DROP_W-1:0] dropCnt_reg, dropCnt_next;
    logic [2:0]     pinsPrev_reg;
    logic           refPrev_reg;
    logic [31:0]    effRatio_reg, effRatio_next;
    logic           dropReq_reg;

    assign modalSel  = modal_reg[modeIdx*MODAL_SET_W +: MODAL_SET_W];
    assign curRatio  = ratio_reg[modeIdx];
    assign spec      = decodeSpecial(global_reg.specialFunc, spPin);
    assign refEdge   = refS & ~refPrev_reg;
    assign refLost   = (refCnt_reg == REF_W'(REF_TIMEOUT_CYCLES));
    assign lockEff   = lockIn & ~refLost & (dropCnt_reg == '0);
    assign auxSrcSel = spec.forceSynth ? AUX_SYNTH : modalSel.auxSrc;
    assign statusWord = {22'h0, dropReq_reg, refLost, lockEff, spPin, modeIdx, auxSrcSel, modalSel.divSel};

    always_comb
    begin
        refCnt_next = refEdge ? '0 : (refLost ? refCnt_reg : refCnt_reg + 1'b1);
        dropCnt_next = (dropCnt_reg != '0) ? dropCnt_reg - 1'b1 : dropCnt_reg;
        if ((modeIdx != pinsPrev_reg[1:0]) ||
            ((spPin != pinsPrev_reg[2]) && (global_reg.specialFunc inside {[3'h3:3'h6]})))
            dropCnt_next = DROP_W'(MODE_SETTLE_CYC);
        // Low bits shifted out are lost; software keeps ratios clear of that
        effRatio_next = spec.rmodEn ? (curRatio >> ({3'h0, modalSel.divSel} + 3'h1))
                                    : curRatio;
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            refCnt_reg   <= '0;
            dropCnt_reg  <= '0;
            pinsPrev_reg <= 3'h0;
            refPrev_reg  <= 1'b0;
            effRatio_reg <= RATIO_RESET;
            dropReq_reg  <= 1'b0;
        end
        else
        begin
            refCnt_reg   <= refCnt_next;
            dropCnt_reg  <= dropCnt_next;
            pinsPrev_reg <= {spPin, modeIdx};
            refPrev_reg  <= refS;
            effRatio_reg <= effRatio_next;
            dropReq_reg  <= (dropCnt_next != '0);
        end
    end

    assign effectiveRatio    = effRatio_reg;
    assign ratioFormatSelect = global_reg.ratioFormat;
    assign lockDropReq       = dropReq_reg;

    // ----------------------------------------
    // Output gating
    // ----------------------------------------
    logic       mainGate_reg, mainGate_next, mainOe_n_reg, mainOe_n_next;
    logic       auxGate_reg, auxGate_next;
    logic [1:0] auxSrc_reg, auxSrc_next;
    logic       mainOut_reg, auxOut_reg, auxOe_n_reg;
    logic       auxLevel;
    logic       auxOutN, auxOeN;

    assign auxLevel = (auxSrc_reg == AUX_REF) ? refS : ((auxSrc_reg == AUX_SYNTH) ? synthS : 1'b0);

    always_comb
    begin
        mainGate_next = mainGate_reg;
        mainOe_n_next = mainOe_n_reg;
        auxGate_next  = auxGate_reg;
        auxSrc_next   = auxSrc_reg;
        // Gates move only in the low phase so no partial period escapes
        if (!synthS)
        begin
            mainGate_next = ~spec.mainDis & (lockEff | global_reg.outputOnUnlock);
            mainOe_n_next = spec.mainDis;
        end
        if (!auxLevel)
        begin
            auxGate_next = ~spec.auxDis;
            auxSrc_next  = auxSrcSel;
        end
        auxOutN = 1'b0;
        auxOeN  = ~auxGate_reg;
        unique case (auxSrc_reg)
            AUX_REF:   auxOutN = refS & auxGate_reg;
            AUX_SYNTH: auxOutN = synthS & auxGate_reg;
            AUX_LOCK:
            begin
                auxOutN = global_reg.lockDriveCfg ? 1'b0 : ~lockEff;
                auxOeN  = ~auxGate_reg | (global_reg.lockDriveCfg & lockEff);
            end
            default:   auxOutN = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mainGate_reg <= 1'b0;
            mainOe_n_reg <= 1'b0;
            auxGate_reg  <= 1'b0;
            auxSrc_reg   <= AUX_RESERVED;
            mainOut_reg  <= 1'b0;
            auxOut_reg   <= 1'b0;
            auxOe_n_reg  <= 1'b1;
        end
        else
        begin
            mainGate_reg <= mainGate_next;
            mainOe_n_reg <= mainOe_n_next;
            auxGate_reg  <= auxGate_next;
            auxSrc_reg   <= auxSrc_next;
            mainOut_reg  <= synthS & mainGate_reg;
            auxOut_reg   <= auxOutN;
            auxOe_n_reg  <= auxOeN;
        end
    end

    assign mainClkOut  = mainOut_reg;
    assign mainClkOe_n = mainOe_n_reg;
    assign auxOut      = auxOut_reg;
    assign auxOe_n     = auxOe_n_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence seqUnlockLow;
        !lockEff && !global_reg.outputOnUnlock && !synthS;
    endsequence
    sequence seqMainOff;
        global_reg.specialFunc == SPF_MAIN_DIS && spPin && !synthS;
    endsequence

    a_eff_div16: assert property (spec.rmodEn && modalSel.divSel == 2'h3 |=>
        effectiveRatio == {4'h0, $past(curRatio[31:4])}) else $error("ratio not divided by 16");
    a_eff_div2: assert property (spec.rmodEn && modalSel.divSel == 2'h0 |=>
        effectiveRatio == {1'b0, $past(curRatio[31:1])}) else $error("ratio not halved");
    a_eff_passthru: assert property (!spec.rmodEn |=> effectiveRatio == $past(curRatio))
        else $error("ratio changed without modifier");
    a_ratio_kept: assert property (!doWrite |=> $stable(ratio_reg))
        else $error("stored ratio changed");
    a_main_unlock_low: assert property (seqUnlockLow |-> ##2 !mainClkOut)
        else $error("main output not held low on unlock");
    a_main_gate_phase: assert property ($changed(mainGate_reg) |-> !$past(synthS))
        else $error("main gate moved in high phase");
    a_main_hiz: assert property (seqMainOff |=> mainClkOe_n)
        else $error("main output not tristated");
    a_aux_lock_pp: assert property (auxSrc_reg == AUX_LOCK && !global_reg.lockDriveCfg && auxGate_reg
        |=> auxOut == !$past(lockEff) && !auxOe_n) else $error("push-pull lock level wrong");
    a_aux_lock_od: assert property (auxSrc_reg == AUX_LOCK && global_reg.lockDriveCfg && auxGate_reg
        && lockEff |=> auxOe_n && !auxOut) else $error("open-drain lock not floating");
    a_aux_force: assert property (global_reg.specialFunc == SPF_FORCE_AUX && spPin && !auxLevel
        |=> auxSrc_reg == AUX_SYNTH) else $error("aux source not forced");
    a_mode_drop: assert property ($changed(modeIdx) |=> lockDropReq[*8] ##0 !lockEff)
        else $error("lock not dropped on mode change");

endmodule

/* File: verification/pll_core_model.sv */
// Behavioural PLL core: synthesized clock, reference clock and lock
`timescale 1ns/1ns
module pll_core_model
(
    input  wire logic lockEnable,
    input  wire logic lockDropReq,
    output logic      synthClk,
    output logic      refClk,
    output logic      pllLock
);
    initial
    begin
        synthClk = 1'b0;
        forever #40 synthClk = ~synthClk;
    end
    initial
    begin
        refClk = 1'b0;
        forever #50 refClk = ~refClk;
    end
    // Lock falls while the device settles a new mode
    assign pllLock = lockEnable & ~lockDropReq;
endmodule

/* File: verification/tb_clock_ratio_mode_output_ctrl.sv */
// Self-checking bench for the clock ratio control block
`timescale 1ns/1ns
module tb_clock_ratio_mode_output_ctrl;
    import clock_ratio_pkg::*;
    logic        mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready, lockEn, seen;
    logic        modeSelectLow, modeSelectHigh, specialFunctionPin, awready, wready, bvalid, arready;
    logic        rvalid, synthClk, refClk, pllLock, mainClkOut, mainClkOe_n, auxOut, auxOe_n;
    logic        ratioFormatSelect, lockDropReq;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, effectiveRatio, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    int          miscompares, n_compared, cyc;
    clock_ratio_mode_output_ctrl #(.REF_TIMEOUT_CYCLES(64)) u_clock_ratio_mode_output_ctrl (.mclk(mclk),
        .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .modeSelectLow(modeSelectLow), .modeSelectHigh(modeSelectHigh),
        .specialFunctionPin(specialFunctionPin), .pllLock(pllLock), .synthClk(synthClk), .refClk(refClk),
        .mainClkOut(mainClkOut), .mainClkOe_n(mainClkOe_n), .auxOut(auxOut), .auxOe_n(auxOe_n),
        .effectiveRatio(effectiveRatio), .ratioFormatSelect(ratioFormatSelect), .lockDropReq(lockDropReq));
    pll_core_model u_pll_core_model (.lockEnable(lockEn), .lockDropReq(lockDropReq), .synthClk(synthClk),
        .refClk(refClk), .pllLock(pllLock));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp = bresp;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rv = rdata;
        resp = rresp;
    endtask
    task automatic t_rmod();
        rd(RATIO0_OFFSET);
        chk(rv, RATIO_RESET);
        wr(RATIO1_OFFSET, 32'h0004_0000);
        wr(STATUS_OFFSET, 32'hFFFF_FFFF);
        chk(32'(resp), 32'(RESP_SLVERR));
        modeSelectLow <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(lockDropReq), 32'h1);
        wr(GLOBAL_OFFSET, 32'h0000_0018);
        specialFunctionPin <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            wr(MODAL_OFFSET, {16'h0, 8'hAA, 2'b10, 2'(c), 4'hA});
            repeat (6) @(posedge mclk);
            chk(effectiveRatio, 32'h0004_0000 >> (c + 1));
        end
        specialFunctionPin <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(effectiveRatio, 32'h0004_0000);
        rd(RATIO1_OFFSET);
        chk(rv, 32'h0004_0000);
        $display("t_rmod done");
    endtask
    task automatic t_unlock();
        lockEn <= 1'b0;
        repeat (12) @(posedge mclk);
        seen = 1'b0;
        repeat (24) @(posedge mclk) seen |= mainClkOut;
        chk(32'(seen), 32'h0);
        wr(GLOBAL_OFFSET, 32'h0000_0002);
        seen = 1'b0;
        repeat (24) @(posedge mclk) seen |= mainClkOut;
        chk(32'(seen), 32'h1);
        lockEn <= 1'b1;
        $display("t_unlock done");
    endtask
    task automatic t_outdis();
        for (int f = 0; f < 3; f++)
        begin
            wr(GLOBAL_OFFSET, 32'(f << 3));
            specialFunctionPin <= 1'b1;
            repeat (12) @(posedge mclk);
            chk(32'({mainClkOe_n, auxOe_n}), 32'({f != 1, f != 0}));
            specialFunctionPin <= 1'b0;
            repeat (12) @(posedge mclk);
            chk(32'({mainClkOe_n, auxOe_n}), 32'h0);
        end
        $display("t_outdis done");
    endtask
    task automatic t_aux();
        wr(GLOBAL_OFFSET, 32'h0000_003C);
        chk(32'(ratioFormatSelect), 32'h1);
        wr(MODAL_OFFSET, 32'h0000_00C0);
        specialFunctionPin <= 1'b1;
        repeat (12) @(posedge mclk);
        seen = 1'b0;
        repeat (24) @(posedge mclk) seen |= auxOut;
        chk(32'(seen), 32'h1);
        specialFunctionPin <= 1'b0;
        repeat (12) @(posedge mclk);
        chk(32'({auxOut, auxOe_n}), 32'h0);
        lockEn <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(32'({auxOut, auxOe_n}), 32'h2);
        wr(GLOBAL_OFFSET, 32'h0000_003D);
        repeat (2) @(posedge mclk);
        chk(32'({auxOut, auxOe_n}), 32'h0);
        lockEn <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(32'({auxOut, auxOe_n}), 32'h1);
        rd(5'h1D);
        chk(32'(resp), 32'(RESP_SLVERR));
        chk(rv, 32'h0);
        $display("t_aux done");
    endtask
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, lockEn, specialFunctionPin} = '0;
        {modeSelectLow, modeSelectHigh, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        sys_rst = 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk) modeSelectLow <= ~modeSelectLow;
        lockEn <= 1'b1;
        t_rmod();
        t_unlock();
        t_outdis();
        t_aux();
        finish_test();
    end
endmodule
